// File: smr_cfg_bank.sv
// configuration register storage for the span 18h..41h
`timescale 1ns/100ps
module smr_cfg_bank #(
    parameter int N = smr_pkg::CFG_N
) (
    // clock and resets
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   soft_clr,
    // write port
    input  wire logic                   wr_en,
    input  wire logic [7:0]             wr_addr,
    input  wire logic [7:0]             wr_data,
    // read port
    input  wire logic [7:0]             rd_addr,
    output logic      [7:0]             rd_data,
    output logic      [N*8-1:0]         cfg_flat
);
    logic [7:0] mem [N];

    // one byte per slot; holes in the span never store anything
    generate
        for (genvar i = 0; i < N; i++) begin : g_slot
            localparam logic [7:0] A = 8'(smr_pkg::OFS_CFG_FIRST + i);
            localparam logic [7:0] RV = (A == smr_pkg::OFS_SEQ_CH) ?
                                        smr_pkg::SEQ_CH_RESET : smr_pkg::CFG_RESET;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    mem[i] <= RV;
                end else if (soft_clr) begin
                    mem[i] <= RV;
                end else if (wr_en && wr_addr == A && smr_pkg::smr_is_cfg(A)) begin
                    mem[i] <= wr_data;
                end
            end
            assign cfg_flat[i*8 +: 8] = mem[i];
        end
    endgenerate

    // read mux; holes and foreign addresses give zero
    always_comb begin
        rd_data = 8'h00;
        for (int j = 0; j < N; j++) begin
            if (rd_addr == 8'(smr_pkg::OFS_CFG_FIRST + j) && smr_pkg::smr_is_cfg(rd_addr)) begin
                rd_data = mem[j];
            end
        end
    end
endmodule // smr_cfg_bank

// File: smr_core_model.sv
// core-side model that tallies the command pulses of the bank
`timescale 1ns/100ps
module smr_core_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // command pulses from the bank
    input  wire logic       core_reset,
    input  wire logic       trim_start,
    input  wire logic       scan_start,
    input  wire logic       scan_abort,
    // pulse tallies
    output logic      [7:0] n_rst,
    output logic      [7:0] n_trim,
    output logic      [7:0] n_beg,
    output logic      [7:0] n_can
);
    // counting high cycles exposes stuck levels as well as lost pulses
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            n_rst  <= 8'h00;
            n_trim <= 8'h00;
            n_beg  <= 8'h00;
            n_can  <= 8'h00;
        end else begin
            n_rst  <= n_rst + 8'(core_reset);
            n_trim <= n_trim + 8'(trim_start);
            n_beg  <= n_beg + 8'(scan_start);
            n_can  <= n_can + 8'(scan_abort);
        end
    end
endmodule // smr_core_model

// File: smr_pkg.sv
// package of register offsets, fields and reset values for the sensor monitor bank
package smr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    localparam logic [7:0] OFS_STATUS    = 8'h00;
    localparam logic [7:0] OFS_BUF_STAT  = 8'h01;
    localparam logic [7:0] OFS_SUM_STAT  = 8'h02;
    localparam logic [7:0] OFS_FIRST_CH  = 8'h03;
    localparam logic [7:0] OFS_SCAN_STAT = 8'h04;
    localparam logic [7:0] OFS_SUM0_LO   = 8'h08;
    localparam logic [7:0] OFS_SUM0_HI   = 8'h09;
    localparam logic [7:0] OFS_SUM1_LO   = 8'h0a;
    localparam logic [7:0] OFS_SUM1_HI   = 8'h0b;
    localparam logic [7:0] OFS_LOW_FLAGS = 8'h0c;
    localparam logic [7:0] OFS_SOFT_RST  = 8'h14;
    localparam logic [7:0] OFS_TRIM      = 8'h15;
    localparam logic [7:0] OFS_KEY       = 8'h17;
    localparam logic [7:0] OFS_SCAN_BEG  = 8'h1e;
    localparam logic [7:0] OFS_SCAN_CAN  = 8'h1f;
    // plain configuration storage spans 18h..41h, decoded by a table
    localparam logic [7:0] OFS_CFG_FIRST = 8'h18;
    localparam int         CFG_N         = 42;

    localparam logic [3:0] KEY_UNLOCK    = 4'ha;
    localparam logic [3:0] KEY_RESET     = 4'h0;
    localparam int         KEY_MSB       = 3;
    localparam int         CMD_BIT       = 0;
    localparam logic [7:0] CFG_RESET     = 8'h00;
    localparam logic [7:0] SEQ_CH_RESET  = 8'h03;
    localparam logic [7:0] OFS_SEQ_CH    = 8'h20;
    localparam logic [7:0] OFS_MODE_SEL  = 8'h1c;
    localparam int         MODE_MSB      = 2;
    localparam int         HS_BIT        = 2;

    // effective operating modes as reported in status bits 1:0
    localparam logic [1:0] EFF_MANUAL = 2'h0;
    localparam logic [1:0] EFF_AUTON  = 2'h2;
    localparam logic [1:0] EFF_PREC   = 2'h3;

    // which offsets in the configuration span really hold a register
    function automatic logic smr_is_cfg(input logic [7:0] a);
        case (a)
            8'h18, 8'h19, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30,
            8'h34, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3a, 8'h3b, 8'h3c,
            8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h41: smr_is_cfg = 1'b1;
            default:                           smr_is_cfg = 1'b0;
        endcase
    endfunction

    // mode code to the mode actually in effect
    function automatic logic [1:0] smr_mode_decode(input logic [2:0] code);
        case (code)
            3'h6:    smr_mode_decode = EFF_AUTON;
            3'h7:    smr_mode_decode = EFF_PREC;
            default: smr_mode_decode = EFF_MANUAL;
        endcase
    endfunction
endpackage

// File: smr_regs.sv
// register bank top: decode, keyed soft reset, triggers and status views
`timescale 1ns/100ps
module smr_regs #(
    parameter int N = smr_pkg::CFG_N
) (
    // clock and power-up reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // register access from the serial interface
    input  wire logic          wr_en,
    input  wire logic          rd_en,
    input  wire logic [7:0]    addr,
    input  wire logic [7:0]    wr_data,
    output logic      [7:0]    rd_data,
    // general call carrying the software-reset command
    input  wire logic          gcall_reset,
    // live state from the converter core
    input  wire logic          hs_mode,
    input  wire logic [7:0]    buf_status,
    input  wire logic [7:0]    sum_status,
    input  wire logic [7:0]    scan_status,
    input  wire logic [15:0]   sum_ch0,
    input  wire logic [15:0]   sum_ch1,
    input  wire logic [1:0]    low_alarm,
    input  wire logic          alarm_valid,
    input  wire logic [7:0]    alarm_ch_id,
    // pulses and levels toward the core
    output logic               core_reset,
    output logic               trim_start,
    output logic               scan_start,
    output logic               scan_abort,
    output logic      [1:0]    eff_mode,
    output logic      [N*8-1:0] cfg_flat
);
    logic [3:0]  unlock_code_field;
    logic        soft_clr;
    logic [7:0]  cfg_rd;
    logic [1:0]  low_flags;
    logic        first_seen;
    logic [7:0]  first_ch;
    logic [2:0]  function_mode_code;
    logic [7:0]  next_rd_data;
    logic        key_hit;
    logic        rst_wr;
    logic [smr_pkg::KEY_MSB:0] key_wr_nibble;

    // bit position of the sequencer channel register inside the span
    localparam int SEQ_CH_LSB = smr_pkg::DATA_W
                                * int'(smr_pkg::OFS_SEQ_CH - smr_pkg::OFS_CFG_FIRST);

    assign key_hit = (unlock_code_field == smr_pkg::KEY_UNLOCK);
    assign key_wr_nibble = wr_data[smr_pkg::KEY_MSB:0];
    assign rst_wr  = wr_en && addr == smr_pkg::OFS_SOFT_RST && key_hit;
    // soft clear from either the keyed register or the general call
    assign soft_clr = gcall_reset || (rst_wr && wr_data[smr_pkg::CMD_BIT]);

    // key is touched only by power-up and its own writes, never by soft clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            unlock_code_field <= smr_pkg::KEY_RESET;
        end else if (wr_en && addr == smr_pkg::OFS_KEY) begin
            unlock_code_field <= wr_data[smr_pkg::KEY_MSB:0];
        end
    end

    smr_cfg_bank #(.N(N)) smr_cfg_bank_inst (
        .clk      (clk),
        .rst_n    (rst_n),
        .soft_clr (soft_clr),
        .wr_en    (wr_en),
        .wr_addr  (addr),
        .wr_data  (wr_data),
        .rd_addr  (addr),
        .rd_data  (cfg_rd),
        .cfg_flat (cfg_flat)
    );

    // command pulses are registered: one cycle, after the write edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            core_reset <= 1'b0;
            trim_start <= 1'b0;
            scan_start <= 1'b0;
            scan_abort <= 1'b0;
        end else begin
            core_reset <= soft_clr;
            trim_start <= wr_en && addr == smr_pkg::OFS_TRIM
                          && wr_data[smr_pkg::CMD_BIT] && !soft_clr;
            scan_start <= wr_en && addr == smr_pkg::OFS_SCAN_BEG
                          && wr_data[smr_pkg::CMD_BIT] && !soft_clr;
            scan_abort <= wr_en && addr == smr_pkg::OFS_SCAN_CAN
                          && wr_data[smr_pkg::CMD_BIT] && !soft_clr;
        end
    end

    // low alarm flags hold once set; a new alarm beats the clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_flags <= 2'h0;
        end else begin
            low_flags <= (soft_clr ? 2'h0 : low_flags) | low_alarm;
        end
    end

    // only the first alarm's channel is kept until the next clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            first_seen <= 1'b0;
            first_ch   <= 8'h00;
        end else if (soft_clr) begin
            first_seen <= alarm_valid;
            first_ch   <= alarm_valid ? alarm_ch_id : 8'h00;
        end else if (alarm_valid && !first_seen) begin
            first_seen <= 1'b1;
            first_ch   <= alarm_ch_id;
        end
    end

    // mode code lives in the configuration span
    assign function_mode_code = cfg_flat[(smr_pkg::OFS_MODE_SEL - smr_pkg::OFS_CFG_FIRST)*8
                                         +: (smr_pkg::MODE_MSB + 1)];
    assign eff_mode = smr_pkg::smr_mode_decode(function_mode_code);

    // read decode; reserved bits and write-only registers give zeros
    always_comb begin
        next_rd_data = 8'h00;
        case (addr)
            smr_pkg::OFS_STATUS: begin
                next_rd_data[smr_pkg::HS_BIT] = hs_mode;
                next_rd_data[1:0] = eff_mode;
            end
            smr_pkg::OFS_BUF_STAT:  next_rd_data = buf_status;
            smr_pkg::OFS_SUM_STAT:  next_rd_data = sum_status;
            smr_pkg::OFS_FIRST_CH:  next_rd_data = first_ch;
            smr_pkg::OFS_SCAN_STAT: next_rd_data = scan_status;
            smr_pkg::OFS_SUM0_LO:   next_rd_data = sum_ch0[7:0];
            smr_pkg::OFS_SUM0_HI:   next_rd_data = sum_ch0[15:8];
            smr_pkg::OFS_SUM1_LO:   next_rd_data = sum_ch1[7:0];
            smr_pkg::OFS_SUM1_HI:   next_rd_data = sum_ch1[15:8];
            smr_pkg::OFS_LOW_FLAGS: next_rd_data = {6'h00, low_flags};
            smr_pkg::OFS_SOFT_RST:  next_rd_data = 8'h00;
            smr_pkg::OFS_TRIM:      next_rd_data = 8'h00;
            smr_pkg::OFS_KEY:       next_rd_data = {4'h0, unlock_code_field};
            smr_pkg::OFS_SCAN_BEG:  next_rd_data = 8'h00;
            smr_pkg::OFS_SCAN_CAN:  next_rd_data = 8'h00;
            default:                next_rd_data = cfg_rd;
        endcase
    end

    // read data is registered so the serial shifter sees a stable byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else if (rd_en) begin
            rd_data <= next_rd_data;
        end
    end

    // key: survives every clear, takes only the low nibble of its writes
    a_key_keeps: assert property (@(posedge clk) disable iff (!rst_n)
        soft_clr && !(wr_en && addr == smr_pkg::OFS_KEY)
        |=> $stable(unlock_code_field))
        else $error("key changed by soft reset");

    a_key_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && addr == smr_pkg::OFS_KEY
        |=> unlock_code_field == $past(key_wr_nibble))
        else $error("key write lost");

    a_key_read: assert property (@(posedge clk) disable iff (!rst_n)
        rd_en && addr == smr_pkg::OFS_KEY
        |=> rd_data[smr_pkg::KEY_MSB:0] == $past(unlock_code_field))
        else $error("key read wrong");

    a_key_upper: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rd_en) && $past(addr) == smr_pkg::OFS_KEY
        |-> rd_data[7:4] == 4'h0)
        else $error("key upper bits nonzero");

    a_key_gcall: assert property (@(posedge clk) disable iff (!rst_n)
        gcall_reset && !(wr_en && addr == smr_pkg::OFS_KEY)
        |=> $stable(unlock_code_field))
        else $error("key changed by general call");

    // reset register: locked writes vanish, a one resets, a zero does not
    a_locked_reset: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && addr == smr_pkg::OFS_SOFT_RST && !key_hit && !gcall_reset
        |=> !core_reset)
        else $error("reset taken while locked");

    a_reset_cause: assert property (@(posedge clk) disable iff (!rst_n)
        core_reset
        |-> $past(gcall_reset) || $past(rst_wr))
        else $error("core reset without a cause");

    a_unlock_reset: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && addr == smr_pkg::OFS_SOFT_RST && key_hit && wr_data[smr_pkg::CMD_BIT]
        |=> core_reset && cfg_flat[7:0] == smr_pkg::CFG_RESET)
        else $error("unlocked reset missed");

    a_reset_zero: assert property (@(posedge clk) disable iff (!rst_n)
        rst_wr && !wr_data[smr_pkg::CMD_BIT] && !gcall_reset
        |=> !core_reset)
        else $error("reset from a zero write");

    a_reset_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        core_reset && !soft_clr
        |=> !core_reset)
        else $error("core reset longer than one cycle");

    a_gcall_reset: assert property (@(posedge clk) disable iff (!rst_n)
        gcall_reset
        |=> core_reset && cfg_flat[SEQ_CH_LSB +: 8] == smr_pkg::SEQ_CH_RESET)
        else $error("general call did not restore defaults");

    // trigger registers hold nothing readable
    a_cmd_zero: assert property (@(posedge clk) disable iff (!rst_n)
        rd_en && (addr == smr_pkg::OFS_SOFT_RST || addr == smr_pkg::OFS_TRIM)
        |=> rd_data == 8'h00)
        else $error("command register read nonzero");

    a_scan_read: assert property (@(posedge clk) disable iff (!rst_n)
        rd_en && (addr == smr_pkg::OFS_SCAN_BEG || addr == smr_pkg::OFS_SCAN_CAN)
        |=> rd_data == 8'h00)
        else $error("scan register read nonzero");

    // trim trigger: a one launches one pulse, a zero does nothing
    a_trim_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        trim_start
        |-> $past(wr_en) && $past(addr) == smr_pkg::OFS_TRIM)
        else $error("trim pulse without its write");

    a_trim_one: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && addr == smr_pkg::OFS_TRIM && wr_data[smr_pkg::CMD_BIT] && !soft_clr
        |=> trim_start)
        else $error("trim write without pulse");

    a_trim_zero: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && addr == smr_pkg::OFS_TRIM && !wr_data[smr_pkg::CMD_BIT]
        |=> !trim_start)
        else $error("trim pulse from a zero write");

    // scan triggers follow their writes by one cycle
    a_scan_begin: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && addr == smr_pkg::OFS_SCAN_BEG && wr_data[smr_pkg::CMD_BIT] && !soft_clr
        |=> scan_start)
        else $error("scan start missed");

    a_scan_cancel: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && addr == smr_pkg::OFS_SCAN_CAN && wr_data[smr_pkg::CMD_BIT] && !soft_clr
        |=> scan_abort)
        else $error("scan abort missed");

    // sum bytes read live; no snapshot ties the pair together
    a_sum0_low: assert property (@(posedge clk) disable iff (!rst_n)
        rd_en && addr == smr_pkg::OFS_SUM0_LO
        |=> rd_data == 8'($past(sum_ch0)))
        else $error("sum ch0 low byte wrong");

    a_sum1_high: assert property (@(posedge clk) disable iff (!rst_n)
        rd_en && addr == smr_pkg::OFS_SUM1_HI
        |=> rd_data == 8'($past(sum_ch1) >> smr_pkg::DATA_W))
        else $error("sum ch1 high byte wrong");

    // status byte: speed bit, mode in effect, zero upper bits
    a_status_hs: assert property (@(posedge clk) disable iff (!rst_n)
        rd_en && addr == smr_pkg::OFS_STATUS
        |=> rd_data[smr_pkg::HS_BIT] == $past(hs_mode) && rd_data[7:3] == 5'h00)
        else $error("status speed bit wrong");

    a_status_mode: assert property (@(posedge clk) disable iff (!rst_n)
        rd_en && addr == smr_pkg::OFS_STATUS
        |=> rd_data[1:0] == $past(eff_mode))
        else $error("status mode field wrong");

    a_mode_status: assert property (@(posedge clk) disable iff (!rst_n)
        rd_en && addr == smr_pkg::OFS_STATUS && function_mode_code == 3'h7
        |=> rd_data[1:0] == smr_pkg::EFF_PREC)
        else $error("status mode wrong");

    // low flags: a new event beats the clear, held until cleared
    a_flag_latch: assert property (@(posedge clk) disable iff (!rst_n)
        low_flags[0] && !soft_clr
        |=> low_flags[0])
        else $error("low flag dropped");

    a_flag_latch1: assert property (@(posedge clk) disable iff (!rst_n)
        low_flags[1] && !soft_clr
        |=> low_flags[1])
        else $error("low flag 1 dropped");

    a_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
        low_alarm[1]
        |=> low_flags[1])
        else $error("low event not latched");

    a_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
        soft_clr && low_alarm == 2'h0
        |=> low_flags == 2'h0)
        else $error("low flags survived clear");

    a_flag_read: assert property (@(posedge clk) disable iff (!rst_n)
        rd_en && addr == smr_pkg::OFS_LOW_FLAGS
        |=> rd_data == {6'h00, $past(low_flags)})
        else $error("low flags read wrong");

    // first alarm channel: taken once, held, emptied by a clear with no new alarm; a new alarm beats the clear
    a_first_take: assert property (@(posedge clk) disable iff (!rst_n)
        alarm_valid && !first_seen
        |=> first_seen && first_ch == $past(alarm_ch_id))
        else $error("first alarm not taken");

    a_first_hold: assert property (@(posedge clk) disable iff (!rst_n)
        first_seen && !soft_clr
        |=> $stable(first_ch))
        else $error("first alarm overwritten");

    a_first_clear: assert property (@(posedge clk) disable iff (!rst_n)
        soft_clr && !alarm_valid
        |=> !first_seen && first_ch == 8'h00)
        else $error("first alarm survived clear");

    a_first_read: assert property (@(posedge clk) disable iff (!rst_n)
        rd_en && addr == smr_pkg::OFS_FIRST_CH
        |=> rd_data == $past(first_ch))
        else $error("first alarm read wrong");

    // mode decode; reserved codes fall back to manual
    a_mode_auton: assert property (@(posedge clk) disable iff (!rst_n)
        function_mode_code == 3'h6
        |-> eff_mode == smr_pkg::EFF_AUTON)
        else $error("autonomous code misdecoded");

    a_mode_manual: assert property (@(posedge clk) disable iff (!rst_n)
        function_mode_code[2:1] != 2'h3
        |-> eff_mode == smr_pkg::EFF_MANUAL)
        else $error("manual code misdecoded");

    // holes in the map and foreign offsets read zero
    a_hole_zero: assert property (@(posedge clk) disable iff (!rst_n)
        rd_en && addr == 8'h1a
        |=> rd_data == 8'h00)
        else $error("unmapped read nonzero");

    a_foreign_zero: assert property (@(posedge clk) disable iff (!rst_n)
        rd_en && addr == 8'h05
        |=> rd_data == 8'h00)
        else $error("foreign read nonzero");
endmodule // smr_regs

// File: smr_regs_tb.sv
// testbench of the register bank driven through its access port
`timescale 1ns/100ps
module smr_regs_tb;
    logic        clk, rst_n, wr_en, rd_en, gcall_reset, hs_mode, alarm_valid;
    logic [7:0]  addr, wr_data, rd_data, buf_status, sum_status, scan_status;
    logic [7:0]  alarm_ch_id, n_rst, n_trim, n_beg, n_can;
    logic [15:0] sum_ch0, sum_ch1;
    logic [1:0]  low_alarm, eff_mode;
    logic        core_reset, trim_start, scan_start, scan_abort;
    logic [smr_pkg::CFG_N*8-1:0] cfg_flat;
    logic [7:0]  cfg_a [5] = '{8'h38, 8'h39, 8'h40, 8'h41, 8'h36};
    int          miscompares = 0;
    int          total_checks = 0;

    smr_regs smr_regs_inst (.clk(clk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en),
        .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .gcall_reset(gcall_reset),
        .hs_mode(hs_mode), .buf_status(buf_status), .sum_status(sum_status),
        .scan_status(scan_status), .sum_ch0(sum_ch0), .sum_ch1(sum_ch1),
        .low_alarm(low_alarm), .alarm_valid(alarm_valid), .alarm_ch_id(alarm_ch_id),
        .core_reset(core_reset), .trim_start(trim_start), .scan_start(scan_start),
        .scan_abort(scan_abort), .eff_mode(eff_mode), .cfg_flat(cfg_flat));
    smr_core_model smr_core_model_inst (.clk(clk), .rst_n(rst_n),
        .core_reset(core_reset), .trim_start(trim_start), .scan_start(scan_start),
        .scan_abort(scan_abort), .n_rst(n_rst), .n_trim(n_trim), .n_beg(n_beg),
        .n_can(n_can));

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask

    // one write: request held for exactly one sampling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 wr_en = 1'b1;
        addr = a;
        wr_data = d;
        @(posedge clk);
        #1 wr_en = 1'b0;
    endtask

    // one read: data is settled one edge after the request
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        #1 rd_en = 1'b1;
        addr = a;
        @(posedge clk);
        #1 rd_en = 1'b0;
        chk($sformatf("reg %h", a), e, rd_data);
    endtask

    // one cycle of general call with the reset command
    task automatic gcall();
        @(posedge clk);
        #1 gcall_reset = 1'b1;
        @(posedge clk);
        #1 gcall_reset = 1'b0;
    endtask

    // hang guard far beyond the sequence length
    initial begin
        #200000;
        miscompares++;
        give_verdict();
    end

    initial begin
        {rst_n, wr_en, rd_en, gcall_reset, alarm_valid, low_alarm} = '0;
        {addr, wr_data, alarm_ch_id} = '0;
        hs_mode = 1'b1;
        buf_status = 8'h11;
        sum_status = 8'h22;
        scan_status = 8'h44;
        sum_ch0 = 16'h1234;
        sum_ch1 = 16'habcd;
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        rd(8'h17, 8'h00);
        rd(8'h14, 8'h00);
        rd(8'h15, 8'h00);
        rd(8'h20, 8'h03);
        wr(8'h05, 8'hff);
        rd(8'h05, 8'h00);
        wr(8'h1a, 8'hff);
        rd(8'h1a, 8'h00);
        // locked key: reset write must be dropped
        wr(8'h24, 8'h01);
        wr(8'h14, 8'h01);
        repeat (2) @(posedge clk);
        chk("n_rst", 8'h00, n_rst);
        rd(8'h24, 8'h01);
        wr(8'h17, 8'h0a);
        rd(8'h17, 8'h0a);
        wr(8'h14, 8'h00);
        repeat (2) @(posedge clk);
        chk("n_rst", 8'h00, n_rst);
        wr(8'h14, 8'h01);
        repeat (2) @(posedge clk);
        chk("n_rst", 8'h01, n_rst);
        rd(8'h24, 8'h00);
        rd(8'h17, 8'h0a);
        wr(8'h17, 8'h00);
        rd(8'h17, 8'h00);
        wr(8'h24, 8'h02);
        wr(8'h20, 8'h01);
        gcall();
        repeat (2) @(posedge clk);
        chk("n_rst", 8'h02, n_rst);
        chk("cfg byte 20h", 8'h03, cfg_flat[64 +: 8]);
        rd(8'h24, 8'h00);
        // triggers: one pulse per bit0 write, zero writes ignored
        wr(8'h15, 8'h01);
        wr(8'h1e, 8'h01);
        wr(8'h1f, 8'h01);
        wr(8'h15, 8'h00);
        rd(8'h15, 8'h00);
        chk("n_trim", 8'h01, n_trim);
        chk("n_beg", 8'h01, n_beg);
        chk("n_can", 8'h01, n_can);
        rd(8'h1f, 8'h00);
        foreach (cfg_a[i]) begin
            wr(cfg_a[i], cfg_a[i] + 8'h11);
            rd(cfg_a[i], cfg_a[i] + 8'h11);
        end
        rd(8'h08, 8'h34);
        rd(8'h09, 8'h12);
        rd(8'h0a, 8'hcd);
        rd(8'h0b, 8'hab);
        wr(8'h08, 8'h00);
        rd(8'h08, 8'h34);
        rd(8'h01, 8'h11);
        rd(8'h02, 8'h22);
        rd(8'h04, 8'h44);
        // alarm events vanish before the reads: flags must be latched
        @(posedge clk);
        #1 low_alarm = 2'h1;
        alarm_valid = 1'b1;
        alarm_ch_id = 8'h01;
        @(posedge clk);
        #1 low_alarm = 2'h2;
        alarm_ch_id = 8'h00;
        @(posedge clk);
        #1 alarm_valid = 1'b0;
        low_alarm = 2'h0;
        rd(8'h0c, 8'h03);
        rd(8'h03, 8'h01);
        gcall();
        rd(8'h0c, 8'h00);
        rd(8'h03, 8'h00);
        wr(8'h1f, 8'h01);
        for (int i = 0; i < 8; i++) begin
            wr(8'h1c, 8'(i));
            rd(8'h00, {6'h01, (i == 6) ? 2'h2 : (i == 7) ? 2'h3 : 2'h0});
            chk("eff_mode", {6'h00, (i > 5) ? 2'(i - 4) : 2'h0}, {6'h00, eff_mode});
        end
        give_verdict();
    end
endmodule // smr_regs_tb
